// *** core/status_word_mem.sv ***
// Small register file holding the machine status word characters.
`default_nettype none
module status_word_mem #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Write port.
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  // Read port.
  input wire logic [AW-1:0] rd_addr_i,
  output logic [7:0] rd_data_o
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge ref_clk_i)
  begin
    if (wr_en_i)
    begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rd_data_o <= 8'h00;
    end
    else
    begin
      rd_data_o <= mem[rd_addr_i];
    end
  end
endmodule
`default_nettype wire

// *** core/term_status_reply.sv ***
// Terminator selection and one-shot status reply sequencer.
`include "term_status_defs.svh"
`default_nettype none
// Function
// - Terminator value 0 sends CR LF, 1 sends LF CR, 2 sends CR alone, 3 sends LF alone.
// - Power-up and a device or selected device clear restore the CR LF terminator.
// - The selected terminator is appended to every data string and status word sent.
// - Status value 0..5 selects machine status, errors, macros, buffer size, value, switch.
// - After a machine status request and execute, the next talk sends the status word.
// - The status word goes out once per request; later talks send normal readings.
// - Each machine status mode field holds the ASCII digits of the programmed value.
// - After an error request the next talk sends the error word, once per request.
// - The error word is a string of ASCII 0 and 1 characters, one per flag.
// - Any error sets the serial poll error flag and requests service if masked in.
// - Reading the error word clears all its bits and the serial poll error bit.
// - Service requests for errors re-arm only after the error word has been read.
// - The error flag is bit 5 of the serial poll byte, set on any error condition.
module term_status_reply #(
  parameter int NERR = 13,
  parameter int MSW_CHARS = 16
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Bus clears and command path.
  input wire logic bus_clear_i,
  input wire term_status_pkg::cmd_t cmd_i,
  // Talk addressing and byte sink handshake.
  input wire logic talk_start_i,
  input wire logic byte_ready_i,
  // Data sources.
  input wire logic [NERR-1:0] err_set_i,
  input wire logic err_srq_mask_i,
  input wire logic [7:0] reading_char_i,
  input wire logic reading_last_i,
  input wire logic [7:0] alt_char_i,
  input wire logic alt_last_i,
  input wire logic msw_wr_i,
  input wire logic [3:0] msw_addr_i,
  input wire logic [3:0] msw_digit_i,
  // Outputs.
  output term_status_pkg::out_byte_t out_o,
  output logic reading_adv_o,
  output logic alt_adv_o,
  output logic [1:0] term_sel_o,
  output logic [7:0] spoll_o,
  output logic srq_o,
  output logic talking_o
);
  import term_status_pkg::*;

  typedef enum {
    ST_IDLE,
    ST_BODY,
    ST_TERM1,
    ST_TERM2
  } phase_t;

  logic [1:0] term_sel;
  logic [1:0] term_pend;
  logic term_pend_v;
  logic [2:0] stat_pend;
  logic stat_pend_v;
  reply_t reply_arm;
  reply_t reply_cur;
  phase_t phase;
  logic [NERR-1:0] err_bits;
  logic srq_armed;
  logic [4:0] idx;
  logic [7:0] msw_q;
  logic [7:0] next_char;
  logic next_last;
  logic step;
  logic body_hold;

  function automatic logic [7:0] term_char(input logic [1:0] sel, input logic second);
    logic [7:0] c;
    c = `CHAR_LF;
    case (sel)
      `TERM_CR_LF: c = second ? `CHAR_LF : `CHAR_CR;
      `TERM_LF_CR: c = second ? `CHAR_CR : `CHAR_LF;
      `TERM_CR: c = `CHAR_CR;
      default: c = `CHAR_LF;
    endcase
    return c;
  endfunction

  function automatic reply_t map_sel(input logic [2:0] v);
    reply_t r;
    r = REPLY_NORMAL;
    case (v)
      `SEL_MACHINE: r = REPLY_MACHINE;
      `SEL_ERROR: r = REPLY_ERROR;
      `SEL_MACRO: r = REPLY_MACRO;
      `SEL_BUFSIZE: r = REPLY_BUFSIZE;
      `SEL_VALUE: r = REPLY_VALUE;
      `SEL_SWITCH: r = REPLY_SWITCH;
      default: r = REPLY_NORMAL;
    endcase
    return r;
  endfunction

  status_word_mem #(
    .DEPTH(MSW_CHARS),
    .AW(4)
  ) u_msw (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .wr_en_i(msw_wr_i),
    .wr_addr_i(msw_addr_i),
    .wr_data_i(`CHAR_ZERO | {4'h0, msw_digit_i}),
    .rd_addr_i(idx[3:0]),
    .rd_data_o(msw_q)
  );

  // A byte moves when the sink is ready or no byte is waiting to be taken.
  assign step = byte_ready_i || !out_o.valid;

  // Body character and end marker for the reply being sent.
  always_comb
  begin
    next_char = reading_char_i;
    next_last = reading_last_i;
    case (reply_cur)
      REPLY_MACHINE:
      begin
        next_char = msw_q;
        next_last = (idx == 5'(MSW_CHARS - 1));
      end
      REPLY_ERROR:
      begin
        next_char = err_bits[NERR - 1 - idx] ? `CHAR_ONE : `CHAR_ZERO;
        next_last = (idx == 5'(NERR - 1));
      end
      REPLY_NORMAL:
      begin
        next_char = reading_char_i;
        next_last = reading_last_i;
      end
      default:
      begin
        next_char = alt_char_i;
        next_last = alt_last_i;
      end
    endcase
  end

  // Pending command values, applied on execute.
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      term_pend <= `TERM_RESET;
      term_pend_v <= 1'b0;
      stat_pend <= 3'h0;
      stat_pend_v <= 1'b0;
    end
    else if (bus_clear_i || cmd_i.execute)
    begin
      term_pend_v <= 1'b0;
      stat_pend_v <= 1'b0;
    end
    else
    begin
      if (cmd_i.term_valid)
      begin
        term_pend <= cmd_i.term_val;
        term_pend_v <= 1'b1;
      end
      if (cmd_i.stat_valid)
      begin
        stat_pend <= cmd_i.stat_val;
        stat_pend_v <= 1'b1;
      end
    end
  end

  // Terminator selection.
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      term_sel <= `TERM_RESET;
    end
    else if (bus_clear_i)
    begin
      term_sel <= `TERM_RESET;
    end
    else if (cmd_i.execute)
    begin
      if (cmd_i.term_valid)
      begin
        term_sel <= cmd_i.term_val;
      end
      else if (term_pend_v)
      begin
        term_sel <= term_pend;
      end
    end
  end

  // Armed one-shot reply; consumed when a talk starts.
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      reply_arm <= REPLY_NORMAL;
    end
    else if (bus_clear_i)
    begin
      reply_arm <= REPLY_NORMAL;
    end
    else if (cmd_i.execute && (cmd_i.stat_valid || stat_pend_v))
    begin
      reply_arm <= map_sel(cmd_i.stat_valid ? cmd_i.stat_val : stat_pend);
    end
    else if (talk_start_i && phase == ST_IDLE)
    begin
      reply_arm <= REPLY_NORMAL;
    end
  end

  // Output sequencer: body, then one or two terminator characters.
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      phase <= ST_IDLE;
      reply_cur <= REPLY_NORMAL;
      idx <= 5'h0;
      out_o <= '0;
      reading_adv_o <= 1'b0;
      alt_adv_o <= 1'b0;
      talking_o <= 1'b0;
      body_hold <= 1'b0;
    end
    else
    begin
      reading_adv_o <= 1'b0;
      alt_adv_o <= 1'b0;
      if (byte_ready_i)
      begin
        out_o.valid <= 1'b0;
      end
      case (phase)
        ST_IDLE:
        begin
          if (talk_start_i && !bus_clear_i)
          begin
            reply_cur <= reply_arm;
            idx <= 5'h0;
            phase <= ST_BODY;
            talking_o <= 1'b1;
            body_hold <= 1'b1;
          end
        end
        ST_BODY:
        begin
          // Sources and the status memory answer one cycle after an advance or address change,
          // so the body pauses a cycle on entry and after every character.
          if (body_hold)
          begin
            body_hold <= 1'b0;
          end
          else if (step)
          begin
            out_o.valid <= 1'b1;
            out_o.data <= next_char;
            out_o.last <= 1'b0;
            idx <= idx + 5'h1;
            body_hold <= 1'b1;
            reading_adv_o <= (reply_cur == REPLY_NORMAL);
            alt_adv_o <= (reply_cur != REPLY_NORMAL) && (reply_cur != REPLY_MACHINE)
              && (reply_cur != REPLY_ERROR);
            if (next_last)
            begin
              phase <= ST_TERM1;
            end
          end
        end
        ST_TERM1:
        begin
          if (step)
          begin
            out_o.valid <= 1'b1;
            out_o.data <= term_char(term_sel, 1'b0);
            out_o.last <= term_sel[1];
            phase <= term_sel[1] ? ST_IDLE : ST_TERM2;
            talking_o <= !term_sel[1];
          end
        end
        ST_TERM2:
        begin
          if (step)
          begin
            out_o.valid <= 1'b1;
            out_o.data <= term_char(term_sel, 1'b1);
            out_o.last <= 1'b1;
            phase <= ST_IDLE;
            talking_o <= 1'b0;
          end
        end
        default:
        begin
          phase <= ST_IDLE;
        end
      endcase
    end
  end

  // Error word bits: set wins over the clear that follows a read-out.
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      err_bits <= '0;
    end
    else if (reply_cur == REPLY_ERROR && phase == ST_TERM1 && step)
    begin
      err_bits <= err_set_i;
    end
    else
    begin
      err_bits <= err_bits | err_set_i;
    end
  end

  // Serial poll error bit and service request arming.
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      spoll_o <= 8'h00;
      srq_o <= 1'b0;
      srq_armed <= 1'b1;
    end
    else
    begin
      spoll_o[`SPOLL_ERR_BIT] <= |err_bits || |err_set_i;
      if (|err_set_i && srq_armed && err_srq_mask_i)
      begin
        srq_o <= 1'b1;
        srq_armed <= 1'b0;
      end
      else if (reply_cur == REPLY_ERROR && phase == ST_TERM1 && step)
      begin
        // A new masked error in the read-out cycle keeps the request up.
        srq_o <= err_srq_mask_i && |err_set_i;
        srq_armed <= !(err_srq_mask_i && |err_set_i);
      end
    end
  end

  assign term_sel_o = term_sel;
endmodule
`default_nettype wire

// *** inc/term_status_defs.svh ***
// Constants for the terminator and status reply block.
`ifndef TERM_STATUS_DEFS_SVH
`define TERM_STATUS_DEFS_SVH
`define TERM_CR_LF 2'h0
`define TERM_LF_CR 2'h1
`define TERM_CR 2'h2
`define TERM_LF 2'h3
`define TERM_RESET `TERM_CR_LF
`define CHAR_CR 8'h0D
`define CHAR_LF 8'h0A
`define CHAR_ZERO 8'h30
`define CHAR_ONE 8'h31
`define SEL_MACHINE 3'h0
`define SEL_ERROR 3'h1
`define SEL_MACRO 3'h2
`define SEL_BUFSIZE 3'h3
`define SEL_VALUE 3'h4
`define SEL_SWITCH 3'h5
`define SPOLL_ERR_BIT 5
`define MSW_LEN 8'h10
`endif

// *** inc/term_status_pkg.sv ***
// Types for the terminator and status reply block.
`default_nettype none
package term_status_pkg;
  typedef enum logic [2:0] {
    REPLY_NORMAL,
    REPLY_MACHINE,
    REPLY_ERROR,
    REPLY_MACRO,
    REPLY_BUFSIZE,
    REPLY_VALUE,
    REPLY_SWITCH
  } reply_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } out_byte_t;
  typedef struct packed {
    logic term_valid;
    logic [1:0] term_val;
    logic stat_valid;
    logic [2:0] stat_val;
    logic execute;
  } cmd_t;
endpackage
`default_nettype wire

// *** sim/ctrl_sink.sv ***
// Bus controller model that takes reply bytes, stalling when asked.
`default_nettype none
module ctrl_sink
  import term_status_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic slow_i,
  input wire term_status_pkg::out_byte_t out_i,
  output logic ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase;
  logic [7:0] got[$];
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      phase <= 2'h0;
      ready_o <= 1'b0;
    end
    else
    begin
      phase <= phase + 2'h1;
      ready_o <= !slow_i || phase == 2'h3;
    end
  end
  always @(posedge ref_clk_i)
  begin
    if (rst_n_i && out_i.valid && ready_o)
      got.push_back(out_i.data);
  end
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench for the terminator and status reply block.
`include "term_status_defs.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import term_status_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, clr = 1'b0, talk = 1'b0, mask = 1'b1, mwr = 1'b0;
  logic slow = 1'b0, alt_idx = 1'b0, ready, radv, aadv, srq, talking;
  logic [1:0] rd_idx = 2'h0, tsel;
  logic [3:0] maddr = 4'h0, mdig = 4'h0;
  logic [12:0] err = 13'h0000;
  logic [7:0] spoll;
  cmd_t cmd = '0;
  out_byte_t out;
  int error_cnt = 0, checks_done = 0, cyc = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk)
  begin
    if (radv)
      rd_idx <= rd_idx == 2'h2 ? 2'h0 : rd_idx + 2'h1;
    if (aadv)
      alt_idx <= !alt_idx;
  end
  term_status_reply i_dut (.ref_clk_i(clk), .rst_n_i(rst_n), .bus_clear_i(clr), .cmd_i(cmd),
    .talk_start_i(talk), .byte_ready_i(ready), .err_set_i(err), .err_srq_mask_i(mask),
    .reading_char_i(8'h41 + {6'h00, rd_idx}), .reading_last_i(rd_idx == 2'h2),
    .alt_char_i(8'h61 + {7'h00, alt_idx}), .alt_last_i(alt_idx), .msw_wr_i(mwr),
    .msw_addr_i(maddr), .msw_digit_i(mdig), .out_o(out), .reading_adv_o(radv),
    .alt_adv_o(aadv), .term_sel_o(tsel), .spoll_o(spoll), .srq_o(srq), .talking_o(talking));
  ctrl_sink i_sink (.ref_clk_i(clk), .rst_n_i(rst_n), .slow_i(slow), .out_i(out),
    .ready_o(ready));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp(string name, logic [7:0] exp, logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  function automatic string term_str(logic [1:0] t);
    case (t)
      `TERM_CR_LF: return "\r\n";
      `TERM_LF_CR: return "\n\r";
      `TERM_CR: return "\r";
      default: return "\n";
    endcase
  endfunction
  task automatic send(logic tv, logic [1:0] t, logic sv, logic [2:0] s, logic ex);
    cmd <= '{tv, t, sv, s, ex};
    @(posedge clk);
    cmd <= '0;
    @(posedge clk);
  endtask
  task automatic pulse_err(logic [12:0] e);
    err <= e;
    @(posedge clk);
    err <= 13'h0000;
    repeat (3) @(posedge clk);
  endtask
  // Addresses the device to talk and compares the whole byte stream it sends.
  task automatic reply(string name, string exp);
    int n;
    i_sink.got.delete();
    talk <= 1'b1;
    @(posedge clk);
    talk <= 1'b0;
    n = 0;
    while ((n < 3 || talking || out.valid) && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    cmp({name, " length"}, 8'(exp.len()), 8'(i_sink.got.size()));
    foreach (i_sink.got[i])
      if (i < exp.len())
        cmp(name, exp[i], i_sink.got[i]);
    $display("test %s done", name);
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    reply("default", {"ABC", term_str(`TERM_RESET)});
    for (int t = 0; t < 4; t++)
    begin
      slow <= t[0];
      send(1'b1, 2'(t), 1'b0, `SEL_MACHINE, 1'b1);
      reply("terminator", {"ABC", term_str(2'(t))});
    end
    send(1'b1, `TERM_CR_LF, 1'b0, `SEL_MACHINE, 1'b0);
    reply("pending", {"ABC", term_str(`TERM_LF)});
    send(1'b0, `TERM_LF, 1'b0, `SEL_MACHINE, 1'b1);
    cmp("term_sel", 8'h00, {6'h00, tsel});
    send(1'b1, `TERM_CR, 1'b0, `SEL_MACHINE, 1'b1);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    @(posedge clk);
    cmp("term_sel clear", 8'h00, {6'h00, tsel});
    for (int i = 0; i < 16; i++)
    begin
      mwr <= 1'b1;
      maddr <= 4'(i);
      mdig <= 4'(i % 10);
      @(posedge clk);
    end
    mwr <= 1'b0;
    send(1'b0, `TERM_CR_LF, 1'b1, `SEL_MACHINE, 1'b1);
    reply("status word", {"0123456789012345", term_str(`TERM_CR_LF)});
    reply("after status", {"ABC", term_str(`TERM_CR_LF)});
    pulse_err(13'h1001);
    cmp("spoll", 8'h20, spoll);
    cmp("srq", 8'h01, {7'h00, srq});
    send(1'b0, `TERM_CR_LF, 1'b1, `SEL_ERROR, 1'b1);
    reply("error word", {"1000000000001", term_str(`TERM_CR_LF)});
    cmp("spoll read", 8'h00, spoll);
    cmp("srq read", 8'h00, {7'h00, srq});
    pulse_err(13'h0002);
    cmp("srq again", 8'h01, {7'h00, srq});
    mask <= 1'b0;
    send(1'b0, `TERM_CR_LF, 1'b1, `SEL_ERROR, 1'b1);
    reply("second error", {"0000000000010", term_str(`TERM_CR_LF)});
    pulse_err(13'h0004);
    cmp("srq masked", 8'h00, {7'h00, srq});
    cmp("spoll masked", 8'h20, spoll);
    reply("after error", {"ABC", term_str(`TERM_CR_LF)});
    for (int s = 2; s < 6; s++)
    begin
      send(1'b0, `TERM_CR_LF, 1'b1, 3'(s), 1'b1);
      reply("alternate", {"ab", term_str(`TERM_CR_LF)});
    end
    give_verdict();
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      give_verdict();
    end
  end
endmodule
`default_nettype wire

// *** sim/term_status_reply_sva.sv ***
// Port assertions for the terminator and status reply block.
`include "term_status_defs.svh"
`default_nettype none
module term_status_reply_sva
  import term_status_pkg::*;
#(
  parameter int NERR = 13
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic bus_clear_i,
  input wire term_status_pkg::cmd_t cmd_i,
  input wire logic talk_start_i,
  input wire logic byte_ready_i,
  input wire logic [NERR-1:0] err_set_i,
  input wire logic err_srq_mask_i,
  input wire term_status_pkg::out_byte_t out_o,
  input wire logic [1:0] term_sel_o,
  input wire logic [7:0] spoll_o,
  input wire logic srq_o,
  input wire logic talking_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_spoll_unused_zero: assert property (spoll_o[7:6] == 2'h0 && spoll_o[4:0] == 5'h00)
    else $error("serial poll bit other than error set");
  a_clear_term: assert property (bus_clear_i && !cmd_i.execute |=> term_sel_o == `TERM_RESET)
    else $error("bus clear left terminator");
  a_out_holds: assert property (out_o.valid && !byte_ready_i |=> $stable(out_o))
    else $error("byte changed while stalled");
  a_err_flag_set: assert property (|err_set_i |-> ##[1:2] spoll_o[`SPOLL_ERR_BIT])
    else $error("error flag not set");
  a_srq_cause: assert property ($rose(srq_o) |-> $past(err_srq_mask_i && |err_set_i))
    else $error("service request without masked error");
  a_talk_begins: assert property (talk_start_i && !talking_o && !bus_clear_i |=> talking_o)
    else $error("talk not started");
  a_first_byte: assert property ($rose(talking_o) |-> ##[1:3] out_o.valid)
    else $error("reply byte late");
  a_term_last: assert property (out_o.valid && out_o.last |-> out_o.data ==
    ((term_sel_o == `TERM_LF_CR || term_sel_o == `TERM_CR) ? `CHAR_CR : `CHAR_LF))
    else $error("wrong final terminator");
  cover property (out_o.valid && out_o.last && term_sel_o == `TERM_LF);
  cover property ($rose(srq_o));
  cover property (out_o.valid && !byte_ready_i);
endmodule
bind term_status_reply term_status_reply_sva #(.NERR(NERR)) i_sva (.ref_clk_i(ref_clk_i),
  .rst_n_i(rst_n_i), .bus_clear_i(bus_clear_i), .cmd_i(cmd_i), .talk_start_i(talk_start_i),
  .byte_ready_i(byte_ready_i), .err_set_i(err_set_i), .err_srq_mask_i(err_srq_mask_i),
  .out_o(out_o), .term_sel_o(term_sel_o), .spoll_o(spoll_o), .srq_o(srq_o),
  .talking_o(talking_o));
`default_nettype wire
